// ---- src/sap_regs.svh ----
`ifndef SAP_REGS_SVH
`define SAP_REGS_SVH

`define SAP_TARGET_ADDR 7'h48
`define SAP_SYS_CLK_HZ 50000000
`define SAP_SCL_MAX_HZ 1000000
`define SAP_SCL_MIN_CYC (`SAP_SYS_CLK_HZ / `SAP_SCL_MAX_HZ)
`define SAP_PROTO_A_NAD 8'h5A
`define SAP_PCB_SESSION_END 8'hE5
`define SAP_GP_RELEASE 8'hC2
`define SAP_KEYSET_RECOVERY 8'h0C
`define SAP_KEYSET_PLATFORM 8'h0B
`define SAP_RSP_DEPTH 64
`define SAP_CERT_FILE_SIZE 16'h0400

`endif

// ---- src/sap_pkg.sv ----
package sap_pkg;
	typedef enum logic {
		SAP_PROTO_T1,
		SAP_PROTO_GP
	} sap_proto_t;

	typedef enum {
		SAP_IDLE,
		SAP_ADDR,
		SAP_ADDR_ACK,
		SAP_RX,
		SAP_RX_ACK,
		SAP_TX,
		SAP_TX_ACK,
		SAP_IGNORE
	} sap_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} sap_pins_t;

	typedef struct packed {
		logic power_down;
		logic core_clk_run;
		logic supply_on;
		logic vout_on;
	} sap_power_t;
endpackage

// ---- src/sap_target.sv ----
// Behaviour
// - answer as target at seven-bit address 0x48 after power-up
// - work with serial clock up to 1 MHz; host stays at or below (the sap_host test host runs at 6.25 MHz)
// - pick transport protocol from first frame, keep it for the session
// - session-end or release request puts device into power-down
// - power-down stops internal clocks, keeps processor and memory contents
// - outputs hold their level throughout power-down
// - falling edge on data line wakes from power-down
// - low deep-sleep request pin forces deep power-down
// - deep power-down switches internal supply and supply output off
// - deep power-down loses internal state
// - raising deep-sleep request pin leaves deep power-down
// - certificate file is DER bytes then zero padding to fixed size
// - recovery key set authentication opens channel and unlocks key set 11 rewrite (key set 11 authentication also unlocks it here)
`timescale 1ns/1ps
`include "sap_regs.svh"

module sap_target #(
	parameter logic [6:0] TARGET_ADDR = `SAP_TARGET_ADDR,
	parameter int RSP_DEPTH = `SAP_RSP_DEPTH,
	parameter logic [15:0] CERT_FILE_SIZE = `SAP_CERT_FILE_SIZE
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire sap_pkg::sap_pins_t pins_in,
	input wire logic deep_sleep_request_n,
	output logic sda_out,
	output logic sda_oe,
	output logic [7:0] cmd_byte,
	output logic cmd_valid,
	output logic cmd_end,
	output logic cmd_busy,
	input wire logic rsp_wr,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_done,
	output sap_pkg::sap_proto_t proto_sel,
	output logic proto_locked,
	output sap_pkg::sap_power_t power,
	input wire logic auth_ok,
	input wire logic [7:0] key_set_number,
	output logic secure_channel_keys_open,
	output logic key11_write_allowed,
	input wire logic [15:0] cert_index,
	input wire logic [15:0] cert_der_len,
	input wire logic [7:0] cert_der_byte,
	output logic [7:0] cert_byte
);
	localparam int PW = $clog2(RSP_DEPTH + 1);

	sap_pkg::sap_pins_t pin_meta;
	sap_pkg::sap_pins_t pin_sync;
	sap_pkg::sap_pins_t pin_prev;
	logic dsr_meta;
	logic dsr_sync;
	logic deep;
	logic pd;
	logic run;
	logic soft_clr;
	logic scl_rise;
	logic scl_fall;
	logic sda_fall;
	logic start_cond;
	logic stop_cond;
	sap_pkg::sap_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] tx_shift;
	logic rw;
	logic [7:0] rx_count;
	logic wrote;
	logic session_end_seen;
	logic [7:0] rsp_mem [RSP_DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic rsp_complete;
	logic [7:0] next_tx;

	// pins cross into sys_clk through two flops; the second stage and its one-cycle delayed copy feed logic
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= '1;
			pin_sync <= '1;
			pin_prev <= '1;
			dsr_meta <= 1'b1;
			dsr_sync <= 1'b1;
		end else begin
			pin_meta <= pins_in;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
			dsr_meta <= deep_sleep_request_n;
			dsr_sync <= dsr_meta;
		end
	end

	// edges come from sampled levels; 50 cycles per bit at 1 MHz leaves ample margin
	assign scl_rise = pin_sync.scl & ~pin_prev.scl;
	assign scl_fall = ~pin_sync.scl & pin_prev.scl;
	assign sda_fall = ~pin_sync.sda & pin_prev.sda;
	assign start_cond = sda_fall & pin_sync.scl & pin_prev.scl;
	assign stop_cond = pin_sync.sda & ~pin_prev.sda & pin_sync.scl & pin_prev.scl;
	assign soft_clr = deep;
	assign run = ~pd & ~deep;
	assign next_tx = (rd_ptr < wr_ptr) ? rsp_mem[rd_ptr[$clog2(RSP_DEPTH)-1:0]] : 8'hFF;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			deep <= 1'b0;
		end else begin
			deep <= ~dsr_sync;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pd <= 1'b0;
		end else if (deep) begin
			pd <= 1'b0;
		end else if (pd && sda_fall) begin
			pd <= 1'b0;
		end else if (run && stop_cond && wrote && session_end_seen) begin
			pd <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			power <= '{power_down: 1'b0, core_clk_run: 1'b1, supply_on: 1'b1, vout_on: 1'b1};
		end else begin
			power.power_down <= pd;
			power.core_clk_run <= ~pd & ~deep;
			power.supply_on <= ~deep;
			power.vout_on <= ~deep;
		end
	end

	// bus state machine; frozen in power-down except that a start wakes it at once
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= sap_pkg::SAP_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			tx_shift <= 8'hFF;
			rw <= 1'b0;
			sda_oe <= 1'b0;
		end else if (soft_clr) begin
			state <= sap_pkg::SAP_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			tx_shift <= 8'hFF;
			rw <= 1'b0;
			sda_oe <= 1'b0;
		end else if (start_cond) begin
			state <= sap_pkg::SAP_ADDR;
			bit_cnt <= 4'h0;
			sda_oe <= 1'b0;
		end else if (pd) begin
			state <= state;
		end else if (stop_cond) begin
			state <= sap_pkg::SAP_IDLE;
			sda_oe <= 1'b0;
		end else if (scl_rise) begin
			if (state == sap_pkg::SAP_TX_ACK) begin
				if (pin_sync.sda) begin
					state <= sap_pkg::SAP_IGNORE;
				end
			end else begin
				shift <= {shift[6:0], pin_sync.sda};
				bit_cnt <= bit_cnt + 4'h1;
			end
		end else if (scl_fall) begin
			case (state)
				sap_pkg::SAP_ADDR: begin
					if (bit_cnt == 4'h8) begin
						if (shift[7:1] == TARGET_ADDR && (shift[0] ? rsp_complete : ~cmd_busy)) begin
							state <= sap_pkg::SAP_ADDR_ACK;
							sda_oe <= 1'b1;
							rw <= shift[0];
						end else begin
							state <= sap_pkg::SAP_IGNORE;
						end
					end
				end
				sap_pkg::SAP_ADDR_ACK: begin
					bit_cnt <= 4'h0;
					if (rw) begin
						state <= sap_pkg::SAP_TX;
						tx_shift <= next_tx;
						sda_oe <= ~next_tx[7];
					end else begin
						state <= sap_pkg::SAP_RX;
						sda_oe <= 1'b0;
					end
				end
				sap_pkg::SAP_RX: begin
					if (bit_cnt == 4'h8) begin
						state <= sap_pkg::SAP_RX_ACK;
						sda_oe <= 1'b1;
					end
				end
				sap_pkg::SAP_RX_ACK: begin
					state <= sap_pkg::SAP_RX;
					bit_cnt <= 4'h0;
					sda_oe <= 1'b0;
				end
				sap_pkg::SAP_TX: begin
					if (bit_cnt == 4'h8) begin
						state <= sap_pkg::SAP_TX_ACK;
						sda_oe <= 1'b0;
					end else begin
						tx_shift <= {tx_shift[6:0], 1'b1};
						sda_oe <= ~tx_shift[6];
					end
				end
				sap_pkg::SAP_TX_ACK: begin
					state <= sap_pkg::SAP_TX;
					bit_cnt <= 4'h0;
					tx_shift <= next_tx;
					sda_oe <= ~next_tx[7];
				end
				default: begin
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// command bytes, frame tracking and protocol choice
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_byte <= 8'h00;
			cmd_valid <= 1'b0;
			cmd_end <= 1'b0;
			rx_count <= 8'h00;
			wrote <= 1'b0;
			session_end_seen <= 1'b0;
			proto_sel <= sap_pkg::SAP_PROTO_T1;
			proto_locked <= 1'b0;
		end else if (soft_clr) begin
			cmd_valid <= 1'b0;
			cmd_end <= 1'b0;
			rx_count <= 8'h00;
			wrote <= 1'b0;
			session_end_seen <= 1'b0;
			proto_locked <= 1'b0;
		end else if (pd) begin
			cmd_valid <= cmd_valid;
		end else begin
			cmd_valid <= 1'b0;
			cmd_end <= 1'b0;
			if (start_cond) begin
				rx_count <= 8'h00;
				wrote <= 1'b0;
				session_end_seen <= 1'b0;
			end else if (stop_cond && wrote) begin
				cmd_end <= 1'b1;
				wrote <= 1'b0;
			end else if (scl_fall && state == sap_pkg::SAP_RX && bit_cnt == 4'h8) begin
				cmd_byte <= shift;
				cmd_valid <= 1'b1;
				wrote <= 1'b1;
				rx_count <= (rx_count == 8'hFF) ? rx_count : rx_count + 8'h01;
				if (!proto_locked && rx_count == 8'h00) begin
					proto_locked <= 1'b1;
					proto_sel <= (shift == `SAP_PROTO_A_NAD) ? sap_pkg::SAP_PROTO_T1 : sap_pkg::SAP_PROTO_GP;
				end
				if (proto_sel == sap_pkg::SAP_PROTO_T1 && proto_locked && rx_count == 8'h01
					&& shift == `SAP_PCB_SESSION_END) begin
					session_end_seen <= 1'b1;
				end
				// a release in the very frame that picks the protocol still counts
				if ((proto_sel == sap_pkg::SAP_PROTO_GP || !proto_locked) && rx_count == 8'h00
					&& shift == `SAP_GP_RELEASE) begin
					session_end_seen <= 1'b1;
				end
			end
		end
	end

	// one command outstanding: busy from the command's stop until its answer is read out
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_busy <= 1'b0;
			wr_ptr <= '0;
			rd_ptr <= '0;
			rsp_complete <= 1'b0;
		end else if (soft_clr) begin
			cmd_busy <= 1'b0;
			wr_ptr <= '0;
			rd_ptr <= '0;
			rsp_complete <= 1'b0;
		end else if (!pd) begin
			if (stop_cond && wrote && !session_end_seen) begin
				cmd_busy <= 1'b1;
			end else if (rsp_complete && rd_ptr == wr_ptr && stop_cond) begin
				cmd_busy <= 1'b0;
				rsp_complete <= 1'b0;
				wr_ptr <= '0;
				rd_ptr <= '0;
			end
			if (cmd_busy && rsp_wr && !rsp_complete && wr_ptr < PW'(RSP_DEPTH)) begin
				rsp_mem[wr_ptr[$clog2(RSP_DEPTH)-1:0]] <= rsp_data;
				wr_ptr <= wr_ptr + PW'(1);
			end
			if (cmd_busy && rsp_done) begin
				rsp_complete <= 1'b1;
			end
			if (scl_fall && (state == sap_pkg::SAP_TX_ACK || state == sap_pkg::SAP_ADDR_ACK && rw)
				&& rd_ptr < wr_ptr) begin
				rd_ptr <= rd_ptr + PW'(1);
			end
		end
	end

	// recovery or platform key set unlocks rewriting of the platform key set; deep sleep forgets it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			secure_channel_keys_open <= 1'b0;
			key11_write_allowed <= 1'b0;
		end else if (soft_clr) begin
			secure_channel_keys_open <= 1'b0;
			key11_write_allowed <= 1'b0;
		end else if (run && auth_ok) begin
			secure_channel_keys_open <= 1'b1;
			key11_write_allowed <= (key_set_number == `SAP_KEYSET_RECOVERY)
				|| (key_set_number == `SAP_KEYSET_PLATFORM);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cert_byte <= 8'h00;
		end else if (run) begin
			cert_byte <= (cert_index < cert_der_len && cert_index < CERT_FILE_SIZE) ? cert_der_byte : 8'h00;
		end
	end
endmodule

// ---- tb/sap_target_chk.sv ----
`timescale 1ns/1ps
module sap_target_chk (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire sap_pkg::sap_pins_t pins_in,
	input wire logic deep_sleep_request_n,
	input wire logic sda_oe,
	input wire logic cmd_valid,
	input wire logic cmd_busy,
	input wire logic proto_locked,
	input wire sap_pkg::sap_power_t power,
	input wire logic auth_ok,
	input wire logic [7:0] key_set_number,
	input wire logic secure_channel_keys_open,
	input wire logic key11_write_allowed,
	input wire logic [15:0] cert_index,
	input wire logic [15:0] cert_der_len,
	input wire logic [7:0] cert_byte
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// the pin is synchronised, so only a level held five cycles is judged
	sequence s_deep_held;
		!deep_sleep_request_n [*5];
	endsequence
	sequence s_run_held;
		deep_sleep_request_n [*5];
	endsequence
	a_pd_clk_stop: assert property (power.power_down |-> !power.core_clk_run) else $error("clock runs in pd");
	a_pd_hold_out: assert property (power.power_down && $past(power.power_down) |->
		$stable(sda_oe) && $stable(cmd_busy)) else $error("output moved in pd");
	a_pd_sda_wake: assert property (power.power_down && $fell(pins_in.sda) |-> ##[1:5] !power.power_down)
		else $error("no wake on sda fall");
	a_deep_off: assert property (s_deep_held |-> !power.supply_on && !power.vout_on)
		else $error("supply on in deep pd");
	a_deep_lose: assert property (s_deep_held |-> !proto_locked && !secure_channel_keys_open)
		else $error("state kept in deep pd");
	a_deep_exit: assert property (s_run_held |-> power.supply_on && power.vout_on) else $error("supply off");
	// the ack is raised in the same cycle as the byte pulse and stands until the next clock fall
	a_byte_acked: assert property (cmd_valid |-> sda_oe ##1 sda_oe && !cmd_valid)
		else $error("byte taken without ack");
	// power flags lag the internal freeze by one cycle, so a frozen core is excused
	a_key_grant: assert property (auth_ok && key_set_number == 8'h0C && !power.power_down |=>
		!power.core_clk_run || secure_channel_keys_open && key11_write_allowed) else $error("recovery set refused");
	a_cert_pad: assert property (cert_index >= cert_der_len && !power.power_down |=>
		!power.core_clk_run || cert_byte == 8'h00) else $error("padding not zero");
endmodule

// ---- tb/sap_host.sv ----
`timescale 1ns/1ps
module sap_host #(
	parameter time QTR = 40
) (
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	// clock stands high between frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		#QTR scl = 1'b1;
		#QTR r = sda;
		#QTR scl = 1'b0;
		#QTR;
	endtask
	// data falls with clock high: a start, and the wake edge too
	task automatic start();
		sda_low = 1'b1;
		#QTR scl = 1'b0;
		#QTR;
	endtask
	task automatic stop();
		sda_low = 1'b1;
		#QTR scl = 1'b1;
		#QTR sda_low = 1'b0;
		#QTR;
	endtask
	task automatic wr(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rd(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule

// ---- tb/sap_target_tb.sv ----
`timescale 1ns/1ps
module sap_target_tb;
	logic sys_clk, rst_n, deep_n, rsp_wr, rsp_done, auth_ok, ack, scl, host_low, sda_oe;
	logic cmd_valid, cmd_busy, proto_locked, sk_open, k11, sda_out, cmd_end;
	logic [7:0] rsp_data, ksn, der_byte, cmd_byte, cert_byte, d;
	logic [15:0] cert_index, der_len;
	sap_pkg::sap_proto_t proto_sel;
	sap_pkg::sap_power_t power;
	wire logic sda = !(host_low || (sda_oe && !sda_out));
	logic [7:0] rx[$];
	int error_cnt = 0;
	int tests_run = 0;
	int end_cnt = 0;
	sap_host host (.sda(sda), .scl(scl), .sda_low(host_low));
	sap_target uut (.sys_clk(sys_clk), .rst_n(rst_n), .pins_in({scl, sda}), .deep_sleep_request_n(deep_n),
		.sda_out(sda_out), .sda_oe(sda_oe), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .cmd_end(cmd_end),
		.cmd_busy(cmd_busy),
		.rsp_wr(rsp_wr), .rsp_data(rsp_data), .rsp_done(rsp_done), .proto_sel(proto_sel),
		.proto_locked(proto_locked), .power(power), .auth_ok(auth_ok), .key_set_number(ksn),
		.secure_channel_keys_open(sk_open), .key11_write_allowed(k11), .cert_index(cert_index),
		.cert_der_len(der_len), .cert_der_byte(der_byte), .cert_byte(cert_byte));
	always @(posedge sys_clk) if (cmd_valid) rx.push_back(cmd_byte);
	always @(posedge sys_clk) if (cmd_end) end_cnt++;
	task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic results();
		if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic frame_w(input logic [6:0] a, input logic [7:0] b0, input logic [7:0] b1);
		logic k;
		@(negedge sys_clk);
		host.start();
		host.wr({a, 1'b0}, ack);
		if (ack) begin
			host.wr(b0, k);
			host.wr(b1, k);
		end
		host.stop();
		repeat (6) @(negedge sys_clk);
	endtask
	task automatic put(input logic [7:0] b, input logic last);
		@(negedge sys_clk);
		rsp_wr = !last;
		rsp_done = last;
		rsp_data = b;
		@(negedge sys_clk);
		rsp_wr = 1'b0;
		rsp_done = 1'b0;
	endtask
	task automatic wake();
		@(negedge sys_clk);
		host.start();
		host.stop();
		repeat (6) @(negedge sys_clk);
		chk("pd after wake", power.power_down, 0);
	endtask
	task automatic t_addr();
		frame_w(7'h49, 8'h5A, 8'h00);
		chk("foreign ack", ack, 0);
		chk("foreign bytes", rx.size(), 0);
		chk("foreign end", end_cnt, 0);
	endtask
	task automatic t_cmd();
		frame_w(7'h48, 8'h5A, 8'h11);
		chk("own ack", ack, 1);
		chk("byte0", rx[0], 8'h5A);
		chk("byte1", rx[1], 8'h11);
		chk("proto", proto_sel, sap_pkg::SAP_PROTO_T1);
		chk("locked", proto_locked, 1);
		chk("busy", cmd_busy, 1);
		frame_w(7'h48, 8'h00, 8'h00);
		chk("busy write ack", ack, 0);
		put(8'hA1, 0);
		put(8'hB2, 0);
		put(8'h00, 1);
		@(negedge sys_clk);
		host.start();
		host.wr({7'h48, 1'b1}, ack);
		host.rd(1'b0, d);
		chk("rsp0", d, 8'hA1);
		host.rd(1'b1, d);
		chk("rsp1", d, 8'hB2);
		host.stop();
		repeat (6) @(negedge sys_clk);
		chk("busy after read", cmd_busy, 0);
		chk("cmd end", end_cnt, 1);
	endtask
	task automatic t_pd();
		frame_w(7'h48, 8'h5A, 8'hE5);
		chk("pd", power.power_down, 1);
		chk("clk", power.core_clk_run, 0);
		wake();
	endtask
	task automatic t_key();
		@(negedge sys_clk);
		ksn = 8'h01;
		auth_ok = 1'b1;
		@(negedge sys_clk);
		chk("chan other", sk_open, 1);
		chk("k11 other", k11, 0);
		ksn = 8'h0C;
		@(negedge sys_clk);
		auth_ok = 1'b0;
		chk("chan", sk_open, 1);
		chk("k11", k11, 1);
	endtask
	task automatic t_deep();
		deep_n = 1'b0;
		repeat (6) @(negedge sys_clk);
		chk("supply", power.supply_on, 0);
		chk("vout", power.vout_on, 0);
		chk("lock", proto_locked, 0);
		chk("chan", sk_open, 0);
		deep_n = 1'b1;
		repeat (6) @(negedge sys_clk);
		chk("supply back", power.supply_on, 1);
		frame_w(7'h48, 8'hC2, 8'h00);
		chk("proto gp", proto_sel, sap_pkg::SAP_PROTO_GP);
		chk("release pd", power.power_down, 1);
		wake();
	endtask
	task automatic cert_at(input logic [15:0] i, input logic [15:0] n, input logic [7:0] e);
		@(negedge sys_clk);
		cert_index = i;
		der_len = n;
		der_byte = 8'h77;
		@(negedge sys_clk);
		chk("cert", cert_byte, e);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// whole sequence needs well under 60 us
	initial begin
		#200000;
		error_cnt++;
		results();
	end
	initial begin
		{rst_n, rsp_wr, rsp_done, auth_ok, rsp_data, ksn, cert_index, der_len, der_byte} = '0;
		deep_n = 1'b1;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk) rst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		t_addr();
		t_cmd();
		t_pd();
		t_key();
		t_deep();
		cert_at(16'h0002, 16'h0003, 8'h77);
		cert_at(16'h0003, 16'h0003, 8'h00);
		cert_at(16'h0400, 16'hFFFF, 8'h00);
		results();
	end
endmodule
bind sap_target sap_target_chk chk (.sys_clk, .rst_n, .pins_in, .deep_sleep_request_n, .sda_oe, .cmd_valid,
	.cmd_busy, .proto_locked, .power, .auth_ok, .key_set_number, .secure_channel_keys_open, .key11_write_allowed,
	.cert_index, .cert_der_len, .cert_byte);
